//--- rtl/bcc_pkg.sv
// package of constants and types for the backup calendar clock
package bcc_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TRIM = 8'h04;
   localparam logic [7:0] OFF_RW = 8'h08;
   localparam logic [7:0] OFF_TIME = 8'h0c;
   localparam logic [7:0] OFF_DATE = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_RST = 8'h18;
   // domain_control_reg fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_BYPASS = 1;
   localparam int CTRL_SRC = 2;
   localparam int CTRL_PRESC_LO = 16;
   // trim_control_reg fields
   localparam int TRIM_MAG_LO = 0;
   localparam int TRIM_DIR = 8;
   // read/write control and status fields
   localparam int RW_READ = 0;
   localparam int RW_WRITE = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_CENT = 1;
   localparam int RST_BIT = 0;
   // time register fields
   localparam int TIME_SEC_LO = 0;
   localparam int TIME_MIN_LO = 8;
   localparam int TIME_HOUR_LO = 16;
   localparam int TIME_FMT = 22;
   localparam int TIME_DAY_LO = 24;
   // date register fields
   localparam int DATE_DATE_LO = 0;
   localparam int DATE_MON_LO = 8;
   localparam int DATE_YEAR_LO = 16;
   // timing and reset values
   localparam logic [15:0] PRESC_RST = 16'h8000;
   localparam logic [15:0] PRESC_XTAL = 16'h8000;
   localparam logic [15:0] PRESC_MAINS60 = 16'h003c;
   localparam logic [15:0] PRESC_MAINS50 = 16'h0032;
   localparam int TRIM_UNIT_SHIFT = 7;
   localparam logic [2:0] DAY_RST = 3'h1;
   localparam logic [5:0] DATE_RST = 6'h01;
   localparam logic [3:0] MON_RST = 4'h1;
   localparam logic [1:0] HSIZE_WORD = 2'h2;

   typedef struct packed {
      logic [6:0] sec;
      logic [6:0] min;
      logic [5:0] hour;
      logic fmt12;
      logic [2:0] day;
      logic [5:0] date;
      logic [3:0] mon;
      logic [7:0] year;
   } bcc_cal_s;

   typedef struct packed {
      logic osc_en;
      logic osc_bypass_bit;
      logic src_in_pin;
      logic [15:0] presc;
      logic [5:0] trim_magnitude;
      logic trim_direction;
      logic rd;
      logic wr;
      logic pend;
      logic century;
      logic [1:0] sync_out;
      logic [1:0] sync_in;
      logic tb_prev;
      logic [16:0] cnt;
      logic sec_tick;
      bcc_cal_s cal;
      bcc_cal_s stage;
      bcc_cal_s snap;
      logic dp_act;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
   } bcc_state_s;
endpackage

//--- rtl/bcc_backup_calendar_clock.sv
// backup calendar clock: timebase, prescaler, trim, bcd calendar, ahb regs
//Function
//- square wave on output pin at 32768 Hz; prescaler set to 32768.
//- 60 Hz mains on input pin; prescaler set to 60.
//- 50 Hz mains sine timebase; prescaler set to 50.
//- trim acts only while prescaler equals 32768.
//- 6-bit trim magnitude, 128 input ticks per unit.
//- trim direction adds ticks (longer second) or subtracts (shorter second).
//- domain ignores power-on, brownout, watchdog and pin resets; state kept.
//- domain resets only on cold start or firmware reset write.
//- seconds are 7-bit bcd, 0 to 59.
//- minutes are 7-bit bcd, 0 to 59.
//- hours 6-bit bcd; 0-23, or pm flag plus 1-12.
//- hour format select: 1 is 12-hour, 0 is 24-hour.
//- weekday 3-bit bcd counts 1 to 7 and wraps.
//- date 6-bit bcd 1-31, limit by month with leap correction.
//- month 4-bit, bcd 1 to 9, then binary 4'ha to 4'hc for 10 to 12.
//- year 8-bit bcd, 0 to 99.
//- one decimal digit per nibble; always-zero bits dropped.
//- year divisible by 4 gives february 29 days.
//- year wrap 99 to 00 raises the century flag.
//- bus copies cross coherently to the low-rate counters.
//- calendar advances on a tick from timebase divided by prescaler.
//- after write session ends, all new values load on one timebase edge.
`timescale 1ns/1ps
module bcc_backup_calendar_clock (
   // clock and cold-start reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // timebase pins, already sliced to logic levels
   input wire logic osc_output_pin,
   input wire logic osc_input_pin,
   // status toward the rest of the chip
   output logic osc_bypass,
   output logic century_flag,
   output logic rtc_busy,
   output logic second_tick
);

   bcc_pkg::bcc_state_s s_q;
   bcc_pkg::bcc_state_s s_d;

   function automatic bcc_pkg::bcc_state_s init_state();
      bcc_pkg::bcc_state_s r;
      r = '0;
      r.presc = bcc_pkg::PRESC_RST;
      r.cal.day = bcc_pkg::DAY_RST;
      r.cal.date = bcc_pkg::DATE_RST;
      r.cal.mon = bcc_pkg::MON_RST;
      r.stage = r.cal;
      r.snap = r.cal;
      return r;
   endfunction

   localparam bcc_pkg::bcc_state_s ST_RST = init_state();

   // two-digit bcd increment; caller handles the wrap
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return {v[7:4], v[3:0] + 4'h1};
   endfunction

   // year in bcd divisible by four
   function automatic logic is_leap(input logic [7:0] y);
      if (y[4]) begin
         return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction

   // last date of a month, bcd
   function automatic logic [5:0] month_end(input logic [3:0] m,
                                            input logic [7:0] y);
      case (m)
         4'h2: return is_leap(y) ? 6'h29 : 6'h28;
         4'h4, 4'h6, 4'h9, 4'hb: return 6'h30;
         default: return 6'h31;
      endcase
   endfunction

   // advance the calendar by one second with carries
   function automatic bcc_pkg::bcc_cal_s advance(input bcc_pkg::bcc_cal_s c,
                                                 output logic cent);
      bcc_pkg::bcc_cal_s n;
      logic day_carry;
      logic [5:0] last;
      n = c;
      cent = 1'b0;
      day_carry = 1'b0;
      last = month_end(c.mon, c.year);
      if (c.sec != 7'h59) begin
         n.sec = 7'(bcd_inc({1'b0, c.sec}));
      end else begin
         n.sec = 7'h00;
         if (c.min != 7'h59) begin
            n.min = 7'(bcd_inc({1'b0, c.min}));
         end else begin
            n.min = 7'h00;
            if (c.fmt12) begin
               if (c.hour[4:0] == 5'h12) begin
                  n.hour = {c.hour[5], 5'h01};
               end else if (c.hour[4:0] == 5'h11) begin
                  n.hour = {~c.hour[5], 5'h12};
                  day_carry = c.hour[5];
               end else begin
                  n.hour = {c.hour[5], 5'(bcd_inc({3'b000, c.hour[4:0]}))};
               end
            end else if (c.hour == 6'h23) begin
               n.hour = 6'h00;
               day_carry = 1'b1;
            end else begin
               n.hour = 6'(bcd_inc({2'b00, c.hour}));
            end
         end
      end
      if (day_carry) begin
         n.day = (c.day == 3'h7) ? 3'h1 : c.day + 3'h1;
         if (c.date != last) begin
            n.date = 6'(bcd_inc({2'b00, c.date}));
         end else begin
            n.date = 6'h01;
            // ten to twelve cannot be two bcd digits in four bits,
            // so those months run on in binary, 4'ha to 4'hc
            if (c.mon != 4'hc) begin
               n.mon = c.mon + 4'h1;
            end else begin
               n.mon = 4'h1;
               if (c.year == 8'h99) begin
                  n.year = 8'h00;
                  cent = 1'b1;
               end else begin
                  n.year = bcd_inc(c.year);
               end
            end
         end
      end
      return n;
   endfunction

   // pack the bus words for reads
   function automatic logic [31:0] time_word(input bcc_pkg::bcc_cal_s c);
      logic [31:0] w;
      w = '0;
      w[bcc_pkg::TIME_SEC_LO +: 7] = c.sec;
      w[bcc_pkg::TIME_MIN_LO +: 7] = c.min;
      w[bcc_pkg::TIME_HOUR_LO +: 6] = c.hour;
      w[bcc_pkg::TIME_FMT] = c.fmt12;
      w[bcc_pkg::TIME_DAY_LO +: 3] = c.day;
      return w;
   endfunction

   function automatic logic [31:0] date_word(input bcc_pkg::bcc_cal_s c);
      logic [31:0] w;
      w = '0;
      w[bcc_pkg::DATE_DATE_LO +: 6] = c.date;
      w[bcc_pkg::DATE_MON_LO +: 4] = c.mon;
      w[bcc_pkg::DATE_YEAR_LO +: 8] = c.year;
      return w;
   endfunction

   function automatic logic [31:0] ctrl_word(input bcc_pkg::bcc_state_s t);
      logic [31:0] w;
      w = '0;
      w[bcc_pkg::CTRL_EN] = t.osc_en;
      w[bcc_pkg::CTRL_BYPASS] = t.osc_bypass_bit;
      w[bcc_pkg::CTRL_SRC] = t.src_in_pin;
      w[bcc_pkg::CTRL_PRESC_LO +: 16] = t.presc;
      return w;
   endfunction

   function automatic logic [31:0] trim_word(input bcc_pkg::bcc_state_s t);
      logic [31:0] w;
      w = '0;
      w[bcc_pkg::TRIM_MAG_LO +: 6] = t.trim_magnitude;
      w[bcc_pkg::TRIM_DIR] = t.trim_direction;
      return w;
   endfunction

   function automatic logic [31:0] rw_word(input bcc_pkg::bcc_state_s t);
      logic [31:0] w;
      w = '0;
      w[bcc_pkg::RW_READ] = t.rd;
      w[bcc_pkg::RW_WRITE] = t.wr;
      return w;
   endfunction

   function automatic logic [31:0] stat_word(input bcc_pkg::bcc_state_s t);
      logic [31:0] w;
      w = '0;
      w[bcc_pkg::STAT_BUSY] = t.pend;
      w[bcc_pkg::STAT_CENT] = t.century;
      return w;
   endfunction

   logic tb_level;
   logic tb_edge;
   logic trim_on;
   logic hour_mark;
   logic [16:0] trim_ticks;
   logic [16:0] limit;
   logic addr_ok;
   logic cent_evt;
   logic wr_rw;
   logic wr_stat;
   bcc_pkg::bcc_cal_s nxt_cal;

   always_comb begin
      s_d = s_q;
      s_d.sec_tick = 1'b0;
      cent_evt = 1'b0;
      nxt_cal = s_q.cal;
      wr_rw = 1'b0;
      wr_stat = 1'b0;

      // pins cross by two flops; only stage two is looked at
      s_d.sync_out = {s_q.sync_out[0], osc_output_pin};
      s_d.sync_in = {s_q.sync_in[0], osc_input_pin};
      tb_level = s_q.src_in_pin ? s_q.sync_in[1] : s_q.sync_out[1];
      s_d.tb_prev = tb_level;
      tb_edge = tb_level & ~s_q.tb_prev & s_q.osc_en;

      // trim once an hour, only at the crystal divide
      trim_on = (s_q.presc == bcc_pkg::PRESC_XTAL);
      hour_mark = (s_q.cal.sec == 7'h00) && (s_q.cal.min == 7'h00);
      trim_ticks = 17'(s_q.trim_magnitude) << bcc_pkg::TRIM_UNIT_SHIFT;
      limit = {1'b0, s_q.presc};
      if (limit == 17'h0) begin
         limit = 17'h1;
      end
      if (trim_on && hour_mark) begin
         if (s_q.trim_direction) begin
            limit = limit + trim_ticks;
         end else begin
            limit = limit - trim_ticks;
         end
      end

      if (tb_edge) begin
         if (s_q.pend) begin
            s_d.cal = s_q.stage;
            s_d.cnt = '0;
            s_d.pend = 1'b0;
         end else if (s_q.cnt >= limit - 17'h1) begin
            s_d.cnt = '0;
            s_d.sec_tick = 1'b1;
            nxt_cal = advance(s_q.cal, cent_evt);
            s_d.cal = nxt_cal;
         end else begin
            s_d.cnt = s_q.cnt + 17'h1;
         end
      end

      // snapshot follows the counters unless a read session freezes it
      if (!s_q.rd) begin
         s_d.snap = s_q.cal;
      end

      // ahb data phase: writes land here
      if (s_q.dp_act && s_q.dp_wr) begin
         case (s_q.dp_addr)
            bcc_pkg::OFF_CTRL: begin
               s_d.osc_en = hwdata[bcc_pkg::CTRL_EN];
               s_d.osc_bypass_bit = hwdata[bcc_pkg::CTRL_BYPASS];
               s_d.src_in_pin = hwdata[bcc_pkg::CTRL_SRC];
               s_d.presc = hwdata[bcc_pkg::CTRL_PRESC_LO +: 16];
            end
            bcc_pkg::OFF_TRIM: begin
               s_d.trim_magnitude = hwdata[bcc_pkg::TRIM_MAG_LO +: 6];
               s_d.trim_direction = hwdata[bcc_pkg::TRIM_DIR];
            end
            bcc_pkg::OFF_RW: wr_rw = 1'b1;
            bcc_pkg::OFF_TIME: begin
               if (s_q.wr) begin
                  s_d.stage.sec = hwdata[bcc_pkg::TIME_SEC_LO +: 7];
                  s_d.stage.min = hwdata[bcc_pkg::TIME_MIN_LO +: 7];
                  s_d.stage.hour = hwdata[bcc_pkg::TIME_HOUR_LO +: 6];
                  s_d.stage.fmt12 = hwdata[bcc_pkg::TIME_FMT];
                  s_d.stage.day = hwdata[bcc_pkg::TIME_DAY_LO +: 3];
               end
            end
            bcc_pkg::OFF_DATE: begin
               if (s_q.wr) begin
                  s_d.stage.date = hwdata[bcc_pkg::DATE_DATE_LO +: 6];
                  s_d.stage.mon = hwdata[bcc_pkg::DATE_MON_LO +: 4];
                  s_d.stage.year = hwdata[bcc_pkg::DATE_YEAR_LO +: 8];
               end
            end
            bcc_pkg::OFF_STAT: wr_stat = hwdata[bcc_pkg::STAT_CENT];
            default: ;
         endcase
      end

      // session bits: no new session while busy or the other is open
      if (wr_rw) begin
         if (!hwdata[bcc_pkg::RW_READ]) begin
            s_d.rd = 1'b0;
         end else if (!s_q.pend && !s_q.wr) begin
            s_d.rd = 1'b1;
         end
         if (!hwdata[bcc_pkg::RW_WRITE]) begin
            s_d.wr = 1'b0;
            if (s_q.wr) begin
               s_d.pend = 1'b1;
            end
         end else if (!s_q.pend && !s_q.rd && !s_q.wr
                      && !hwdata[bcc_pkg::RW_READ]) begin
            s_d.wr = 1'b1;
            s_d.stage = s_q.cal;
         end
      end

      // century flag: write one clears, a new wrap wins
      if (wr_stat) begin
         s_d.century = 1'b0;
      end
      if (cent_evt) begin
         s_d.century = 1'b1;
      end

      // ahb address phase; read data is staged one cycle early
      addr_ok = hsel && htrans[1] && hready
                && (hsize[1:0] == bcc_pkg::HSIZE_WORD) && !hsize[2];
      s_d.dp_act = addr_ok;
      s_d.dp_wr = hwrite;
      s_d.dp_addr = {haddr[7:2], 2'b00};
      if (addr_ok && !hwrite) begin
         case ({haddr[7:2], 2'b00})
            bcc_pkg::OFF_CTRL: s_d.rdata = ctrl_word(s_q);
            bcc_pkg::OFF_TRIM: s_d.rdata = trim_word(s_q);
            bcc_pkg::OFF_RW: s_d.rdata = rw_word(s_q);
            bcc_pkg::OFF_TIME: s_d.rdata = time_word(s_q.wr ? s_q.stage
                                                            : s_q.snap);
            bcc_pkg::OFF_DATE: s_d.rdata = date_word(s_q.wr ? s_q.stage
                                                            : s_q.snap);
            bcc_pkg::OFF_STAT: s_d.rdata = stat_word(s_q);
            default: s_d.rdata = '0;
         endcase
      end

      // firmware domain reset; other system resets have no port here
      if (s_q.dp_act && s_q.dp_wr && s_q.dp_addr == bcc_pkg::OFF_RST
          && hwdata[bcc_pkg::RST_BIT]) begin
         s_d = ST_RST;
      end
   end

   // hresetn stands for the cold start of the backup supply
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata = s_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign osc_bypass = s_q.osc_bypass_bit;
   assign century_flag = s_q.century;
   assign rtc_busy = s_q.pend;
   assign second_tick = s_q.sec_tick;

endmodule // bcc_backup_calendar_clock

//--- sim/bcc_checker.sv
// port assertions for the backup calendar clock
`timescale 1ns/1ps
module bcc_checker (
   // clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // timebase and status
   input wire logic osc_output_pin,
   input wire logic osc_input_pin,
   input wire logic osc_bypass,
   input wire logic century_flag,
   input wire logic rtc_busy,
   input wire logic second_tick
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence acc_s(logic w, logic [7:0] a);
      hsel && htrans[1] && hready && hsize == 3'h2 && hwrite == w
         && haddr[7:0] == a;
   endsequence
   sequence wr_s(logic [7:0] a);
      acc_s(1'b1, a) ##1 1'b1;
   endsequence
   zero_wait_a: assert property (hreadyout) else $error("wait state");
   resp_okay_a: assert property (!hresp) else $error("error response");
   unmapped_rd_a: assert property (acc_s(1'b0, 8'h1c) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   bypass_wr_a: assert property (wr_s(bcc_pkg::OFF_CTRL) |=>
      osc_bypass == $past(hwdata[1])) else $error("bypass not written");
   fw_reset_a: assert property (wr_s(bcc_pkg::OFF_RST) ##0 hwdata[0]
      |=> !osc_bypass && !century_flag && !rtc_busy)
      else $error("firmware reset missed");
   reset_quiet_a: assert property (wr_s(bcc_pkg::OFF_RST) ##0 hwdata[0]
      |=> !second_tick [*8]) else $error("tick after reset");
   cent_clear_a: assert property (wr_s(bcc_pkg::OFF_STAT) ##0 hwdata[1]
      ##1 !second_tick |-> !century_flag) else $error("century not cleared");
   tick_pulse_a: assert property (second_tick |=> !second_tick)
      else $error("tick longer than one cycle");
   busy_bound_a: assert property ($rose(rtc_busy) |-> ##[1:400] !rtc_busy)
      else $error("commit never done");
endmodule // bcc_checker

bind bcc_backup_calendar_clock bcc_checker u_bcc_checker (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .osc_output_pin(osc_output_pin),
   .osc_input_pin(osc_input_pin), .osc_bypass(osc_bypass),
   .century_flag(century_flag), .rtc_busy(rtc_busy),
   .second_tick(second_tick));

//--- sim/bcc_timebase.sv
// timebase model: square wave or sliced mains on the chosen pin
`timescale 1ns/1ps
module bcc_timebase (
   // control from the bench
   input wire logic hclk,
   input wire logic mains,
   input wire logic [3:0] half,
   // timebase pins
   output logic osc_output_pin,
   output logic osc_input_pin
);
   logic wave = 1'b0;
   logic noise = 1'b0;
   logic [3:0] cnt = 4'h0;
   // the floating pin toggles every cycle, so a wrong select shows up
   always @(posedge hclk) begin
      noise <= !noise;
      if (cnt + 4'h1 >= half) begin
         cnt <= 4'h0;
         wave <= !wave;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   assign osc_output_pin = mains ? noise : wave;
   assign osc_input_pin = mains ? wave : noise;
endmodule // bcc_timebase

//--- sim/tb.sv
// self-checking bench for the backup calendar clock
`timescale 1ns/1ps
module tb;
   localparam logic [3:0] HALF = 4'h2;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic osc_output_pin;
   logic osc_input_pin;
   logic osc_bypass;
   logic century_flag;
   logic rtc_busy;
   logic second_tick;
   logic mains;
   logic rd_dp;
   logic [31:0] exp_q[$];
   int mismatches;
   int checks_done;
   int seed;
   int n;
   logic [31:0] r;

   bcc_backup_calendar_clock u_bcc_backup_calendar_clock (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .osc_output_pin(osc_output_pin),
      .osc_input_pin(osc_input_pin), .osc_bypass(osc_bypass),
      .century_flag(century_flag), .rtc_busy(rtc_busy),
      .second_tick(second_tick));
   bcc_timebase u_bcc_timebase (.hclk(hclk), .mains(mains), .half(HALF),
      .osc_output_pin(osc_output_pin), .osc_input_pin(osc_input_pin));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      rd_dp <= !w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask

   // read data is judged in its data phase against the oldest note
   always @(posedge hclk) begin
      if (rd_dp === 1'b1) begin
         chk(hrdata, exp_q.pop_front());
      end
   end

   task automatic tick(output int c);
      c = 0;
      do begin
         @(posedge hclk);
         c++;
      end while (second_tick !== 1'b1 && c < 4000);
   endtask

   task automatic sess(input logic [31:0] t, input logic [31:0] d);
      xfer(1'b1, bcc_pkg::OFF_RW, 32'h2);
      xfer(1'b1, bcc_pkg::OFF_TIME, t);
      xfer(1'b1, bcc_pkg::OFF_DATE, d);
      xfer(1'b1, bcc_pkg::OFF_RW, 32'h0);
      #1;
      chk(rtc_busy, 1'b1);
      n = 0;
      while (rtc_busy !== 1'b0 && n < 400) begin
         @(posedge hclk);
         n++;
      end
      chk(rtc_busy, 1'b0);
   endtask

   function automatic logic [31:0] tw(input logic f, input logic [2:0] dy,
         input logic [5:0] h, input logic [6:0] m, input logic [6:0] s);
      return {5'h0, dy, 1'b0, f, h, 1'b0, m, 1'b0, s};
   endfunction

   function automatic logic [31:0] dw(input logic [7:0] y,
         input logic [3:0] mo, input logic [5:0] dt);
      return {8'h0, y, 4'h0, mo, 2'h0, dt};
   endfunction

   initial begin
      hclk = 1'b0;
      forever #20 hclk = !hclk;
   end

   // the whole run needs under two thousand cycles
   initial begin
      #2000000;
      mismatches++;
      results();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      mains = 1'b0;
      rd_dp = 1'b0;
      mismatches = 0;
      checks_done = 0;
      seed = 10921;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(bcc_pkg::OFF_CTRL, 32'h8000_0000);
      rd(bcc_pkg::OFF_TIME, tw(0, 3'h1, 6'h0, 7'h0, 7'h0));
      rd(bcc_pkg::OFF_DATE, dw(8'h0, 4'h1, 6'h1));
      rd(8'h1c, 32'h0);
      repeat (3) begin
         r = $random(seed);
         xfer(1'b1, bcc_pkg::OFF_TRIM, r);
         rd(bcc_pkg::OFF_TRIM, r & 32'h13f);
      end
      // bypass goes in before the oscillator is enabled
      xfer(1'b1, bcc_pkg::OFF_CTRL, 32'h0004_0002);
      xfer(1'b1, bcc_pkg::OFF_CTRL, 32'h0004_0003);
      rd(bcc_pkg::OFF_CTRL, 32'h0004_0003);
      chk(osc_bypass, 1'b1);
      tick(n);
      tick(n);
      chk(n, 4 * 2 * HALF);
      xfer(1'b1, bcc_pkg::OFF_RW, 32'h1);
      xfer(1'b1, bcc_pkg::OFF_RW, 32'h3);
      rd(bcc_pkg::OFF_RW, 32'h1);
      xfer(1'b1, bcc_pkg::OFF_RW, 32'h0);
      sess(tw(0, 3'h7, 6'h23, 7'h59, 7'h58), dw(8'h04, 4'h2, 6'h28));
      tick(n);
      tick(n);
      rd(bcc_pkg::OFF_TIME, tw(0, 3'h1, 6'h0, 7'h0, 7'h0));
      rd(bcc_pkg::OFF_DATE, dw(8'h04, 4'h2, 6'h29));
      sess(tw(1, 3'h3, 6'h31, 7'h59, 7'h59), dw(8'h05, 4'h2, 6'h28));
      tick(n);
      rd(bcc_pkg::OFF_TIME, tw(1, 3'h4, 6'h12, 7'h0, 7'h0));
      rd(bcc_pkg::OFF_DATE, dw(8'h05, 4'h3, 6'h01));
      mains <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         r = {(i == 0) ? bcc_pkg::PRESC_MAINS60 : bcc_pkg::PRESC_MAINS50,
            16'h0007};
         xfer(1'b1, bcc_pkg::OFF_CTRL, r);
         tick(n);
         tick(n);
         chk(n, r[31:16] * 2 * HALF);
      end
      sess(tw(0, 3'h2, 6'h23, 7'h59, 7'h59), dw(8'h99, 4'hc, 6'h31));
      tick(n);
      chk(century_flag, 1'b1);
      rd(bcc_pkg::OFF_TIME, tw(0, 3'h3, 6'h0, 7'h0, 7'h0));
      rd(bcc_pkg::OFF_DATE, dw(8'h00, 4'h1, 6'h01));
      xfer(1'b1, bcc_pkg::OFF_STAT, 32'h2);
      #1;
      chk(century_flag, 1'b0);
      xfer(1'b1, bcc_pkg::OFF_RST, 32'h1);
      rd(bcc_pkg::OFF_CTRL, 32'h8000_0000);
      rd(bcc_pkg::OFF_STAT, 32'h0);
      results();
   end
endmodule // tb
